// file: hw/sfam_top.v
`timescale 1ns/1ns
`include "sfam_defines.vh"

// What this block does
// - response 11: mute, then ramp outputs to ground
// - response 10: ramp to ground, no mute
// - response 01: mute only, no ramp
// - response resets 00: no silence action
// - width field: 32/32/24/16 bits, resets 11
// - clocks per word field: 32/32/24/16, resets 11
// - format field: RJ, LJ, I2S; resets I2S
// - silence after 2096896/(duration*rate) seconds
// - duration resets zero; zero disables detection
// - 7-bit threshold in dB, resets 104
// - silence needs low level for full duration
// - software restart bit restores field defaults
module sfam_top #(
  parameter [6:0]  DEV_ADDR  = 7'h48,
  parameter [21:0] SIL_LIMIT = `SFAM_SIL_LIMIT
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        sclIn,
  input  wire        sdaIn,
  output wire        sdaOut,
  output wire        sdaOe,
  input  wire        bitClkIn,
  input  wire        lrClkIn,
  input  wire        serDataIn,
  output reg  [31:0] sampleLeft_q,
  output reg  [31:0] sampleRight_q,
  output reg         sampleValid_q,
  output reg         silenceActive_q,
  output reg         muteAll_q,
  output reg         rampToGround_q
);

  // ----------------------------------------
  // register access
  // ----------------------------------------
  wire [7:0] regAddr;
  wire [7:0] wrData;
  wire       wrEn;
  reg  [7:0] rdData;

  sfam_i2c_slave #(
    .DEV_ADDR (DEV_ADDR)
  ) u_i2c (
    .clk     (clk),
    .rst_b   (rst_b),
    .sclIn   (sclIn),
    .sdaIn   (sdaIn),
    .sdaOe   (sdaOe),
    .regAddr (regAddr),
    .wrData  (wrData),
    .wrEn    (wrEn),
    .rdData  (rdData)
  );

  // open drain: only ever pulls low
  assign sdaOut = 1'b0;

  reg [1:0] respMode_q;
  reg [1:0] wordWidth_q;
  reg [1:0] clocksPerWord_q;
  reg [1:0] frameFormat_q;
  reg [7:0] silTime_q;
  reg [6:0] silThresh_q;

  wire softRestart = wrEn && regAddr == `SFAM_REG_SYSTEM && wrData[`SFAM_SOFT_RESET_BIT];

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      respMode_q      <= `SFAM_RESP_RST;
      wordWidth_q     <= `SFAM_WIDTH_RST;
      clocksPerWord_q <= `SFAM_CPW_RST;
      frameFormat_q   <= `SFAM_FMT_RST;
      silTime_q       <= `SFAM_SIL_TIME_RST;
      silThresh_q     <= `SFAM_THRESH_RST;
    end else if (softRestart) begin
      respMode_q      <= `SFAM_RESP_RST;
      wordWidth_q     <= `SFAM_WIDTH_RST;
      clocksPerWord_q <= `SFAM_CPW_RST;
      frameFormat_q   <= `SFAM_FMT_RST;
      silTime_q       <= `SFAM_SIL_TIME_RST;
      silThresh_q     <= `SFAM_THRESH_RST;
    end else if (wrEn) begin
      case (regAddr)
        `SFAM_REG_SERIAL_FMT: begin
          respMode_q      <= wrData[`SFAM_RESP_MSB:`SFAM_RESP_LSB];
          wordWidth_q     <= wrData[`SFAM_WIDTH_MSB:`SFAM_WIDTH_LSB];
          clocksPerWord_q <= wrData[`SFAM_CPW_MSB:`SFAM_CPW_LSB];
          frameFormat_q   <= wrData[`SFAM_FMT_MSB:`SFAM_FMT_LSB];
        end
        `SFAM_REG_SIL_TIME: begin
          silTime_q <= wrData;
        end
        `SFAM_REG_SIL_THRESH: begin
          silThresh_q <= wrData[`SFAM_THRESH_MSB:0];
        end
        default: begin
        end
      endcase
    end
  end

  always @* begin
    case (regAddr)
      `SFAM_REG_SERIAL_FMT: rdData = {respMode_q, wordWidth_q, clocksPerWord_q, frameFormat_q};
      `SFAM_REG_SIL_TIME:   rdData = silTime_q;
      `SFAM_REG_SIL_THRESH: rdData = {1'b0, silThresh_q};
      default:              rdData = 8'h00;
    endcase
  end

  // ----------------------------------------
  // serial input sampling
  // ----------------------------------------
  reg [1:0] bclkSync;
  reg [1:0] lrSync;
  reg [1:0] sdSync;
  reg       bclkP;
  reg       lrP;
  reg [5:0] bitCnt_q;
  reg [31:0] shift_q;

  wire bclkRise = bclkSync[1] & ~bclkP;
  wire lrNow    = lrSync[1];

  // slot and word lengths in bits
  function [5:0] lenBits;
    input [1:0] code;
    begin
      case (code)
        `SFAM_LEN_16: lenBits = 6'd16;
        `SFAM_LEN_24: lenBits = 6'd24;
        default:      lenBits = 6'd32;
      endcase
    end
  endfunction

  wire [5:0] slotLen  = lenBits(clocksPerWord_q);
  wire [5:0] wordLen  = lenBits(wordWidth_q);
  wire       isI2s    = frameFormat_q == `SFAM_FMT_I2S;
  wire       isLj     = frameFormat_q == `SFAM_FMT_LJ;
  // i2s data trails the word-select change by one bit clock
  wire [5:0] capIdx   = isI2s ? slotLen : slotLen - 6'd1;
  // an i2s word ends on the next word-select change, so it belongs to the previous half
  wire       leftHalf = isI2s ? ~lrP : lrNow;
  wire       lrEdge   = lrNow ^ lrP;
  wire [31:0] nextShift = {shift_q[30:0], sdSync[1]};

  // ----------------------------------------
  // word extraction and level check
  // ----------------------------------------
  wire [5:0]  padBits  = (wordLen > slotLen) ? 6'd0 : slotLen - wordLen;
  wire [31:0] slotMask = (slotLen == 6'd32) ? 32'hffffffff : ((32'h00000001 << slotLen) - 32'h00000001);
  wire [31:0] slotBits = nextShift & slotMask;
  wire [31:0] rawWord  = (isI2s || isLj) ? (slotBits >> padBits) : slotBits;
  wire [31:0] aligned  = rawWord << (6'd32 - wordLen);
  wire [31:0] magnitude = aligned[31] ? ~aligned : aligned;
  wire [13:0] dbProd   = silThresh_q * `SFAM_DB_MUL;
  wire [4:0]  dbShift  = dbProd[13:`SFAM_DB_SHIFT];
  wire [31:0] levelLim = `SFAM_FULL_SCALE >> dbShift;
  wire        wordQuiet = magnitude < levelLim;
  wire        capture  = bclkRise && (isI2s || !lrEdge) && bitCnt_q == capIdx;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bclkSync      <= 2'h0;
      lrSync        <= 2'h0;
      sdSync        <= 2'h0;
      bclkP         <= 1'b0;
      lrP           <= 1'b0;
      bitCnt_q      <= 6'h00;
      shift_q       <= 32'h00000000;
      sampleLeft_q  <= 32'h00000000;
      sampleRight_q <= 32'h00000000;
      sampleValid_q <= 1'b0;
    end else begin
      bclkSync      <= {bclkSync[0], bitClkIn};
      lrSync        <= {lrSync[0], lrClkIn};
      sdSync        <= {sdSync[0], serDataIn};
      bclkP         <= bclkSync[1];
      sampleValid_q <= 1'b0;
      if (bclkRise) begin
        lrP     <= lrNow;
        shift_q <= nextShift;
        if (lrEdge) begin
          bitCnt_q <= 6'h01;
        end else if (bitCnt_q != 6'h3f) begin
          bitCnt_q <= bitCnt_q + 6'h01;
        end
      end
      if (capture) begin
        if (leftHalf) begin
          sampleLeft_q <= aligned;
        end else begin
          sampleRight_q <= aligned;
          sampleValid_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // silence timer and response
  // ----------------------------------------
  localparam [1:0] RSP_IDLE = 2'h0;
  localparam [1:0] RSP_MUTE = 2'h1;
  localparam [1:0] RSP_RAMP = 2'h2;

  reg [21:0] silAcc_q;
  reg [21:0] silAcc_d;
  reg        frameQuiet_q;
  reg [1:0]  rspState_q;

  always @* begin
    silAcc_d = silAcc_q;
    if (capture) begin
      if (!wordQuiet || silTime_q == 8'h00) begin
        silAcc_d = 22'h000000;
      end else if (!leftHalf && frameQuiet_q && silAcc_q < SIL_LIMIT) begin
        // one step of the duration per frame: silence after limit/duration frames
        silAcc_d = silAcc_q + {14'h0000, silTime_q};
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      silAcc_q        <= 22'h000000;
      frameQuiet_q    <= 1'b1;
      silenceActive_q <= 1'b0;
      rspState_q      <= RSP_IDLE;
      muteAll_q       <= 1'b0;
      rampToGround_q  <= 1'b0;
    end else begin
      silAcc_q <= silAcc_d;
      if (capture && leftHalf) begin
        frameQuiet_q <= wordQuiet;
      end
      if (silTime_q == 8'h00) begin
        silenceActive_q <= 1'b0;
      end else if (capture && !wordQuiet) begin
        silenceActive_q <= 1'b0;
      end else if (silAcc_q >= SIL_LIMIT) begin
        silenceActive_q <= 1'b1;
      end
      case (rspState_q)
        RSP_IDLE: begin
          muteAll_q      <= 1'b0;
          rampToGround_q <= 1'b0;
          if (silenceActive_q) begin
            if (respMode_q == `SFAM_RESP_MUTE || respMode_q == `SFAM_RESP_MUTE_RAMP) begin
              muteAll_q  <= 1'b1;
              rspState_q <= RSP_MUTE;
            end else if (respMode_q == `SFAM_RESP_RAMP) begin
              rampToGround_q <= 1'b1;
              rspState_q     <= RSP_RAMP;
            end
          end
        end
        RSP_MUTE: begin
          if (!silenceActive_q || respMode_q == `SFAM_RESP_NONE) begin
            muteAll_q  <= 1'b0;
            rspState_q <= RSP_IDLE;
          end else if (respMode_q == `SFAM_RESP_MUTE_RAMP) begin
            rampToGround_q <= 1'b1;
            rspState_q     <= RSP_RAMP;
          end
        end
        RSP_RAMP: begin
          if (!silenceActive_q || respMode_q == `SFAM_RESP_NONE || respMode_q == `SFAM_RESP_MUTE) begin
            muteAll_q      <= 1'b0;
            rampToGround_q <= 1'b0;
            rspState_q     <= RSP_IDLE;
          end
        end
        default: begin
          rspState_q <= RSP_IDLE;
        end
      endcase
    end
  end

endmodule // sfam_top

// file: hw/sfam_defines.vh
`ifndef SFAM_DEFINES_VH
`define SFAM_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SFAM_REG_SYSTEM      8'h00
`define SFAM_REG_SERIAL_FMT  8'h02
`define SFAM_REG_RSVD_THREE  8'h03
`define SFAM_REG_SIL_TIME    8'h04
`define SFAM_REG_SIL_THRESH  8'h05

// ----------------------------------------
// field positions
// ----------------------------------------
`define SFAM_SOFT_RESET_BIT  0
`define SFAM_RESP_MSB        7
`define SFAM_RESP_LSB        6
`define SFAM_WIDTH_MSB       5
`define SFAM_WIDTH_LSB       4
`define SFAM_CPW_MSB         3
`define SFAM_CPW_LSB         2
`define SFAM_FMT_MSB         1
`define SFAM_FMT_LSB         0
`define SFAM_THRESH_MSB      6

// ----------------------------------------
// reset values
// ----------------------------------------
`define SFAM_RESP_RST        2'h0
`define SFAM_WIDTH_RST       2'h3
`define SFAM_CPW_RST         2'h3
`define SFAM_FMT_RST         2'h0
`define SFAM_SIL_TIME_RST    8'h00
`define SFAM_THRESH_RST      7'h68

// ----------------------------------------
// encodings
// ----------------------------------------
`define SFAM_RESP_NONE       2'h0
`define SFAM_RESP_MUTE       2'h1
`define SFAM_RESP_RAMP       2'h2
`define SFAM_RESP_MUTE_RAMP  2'h3
`define SFAM_LEN_16          2'h0
`define SFAM_LEN_24          2'h1
`define SFAM_FMT_I2S         2'h0
`define SFAM_FMT_LJ          2'h1

// ----------------------------------------
// silence timing and level scaling
// ----------------------------------------
`define SFAM_SIL_LIMIT       22'h1fff00
`define SFAM_DB_MUL          8'h55
`define SFAM_DB_SHIFT        9
`define SFAM_FULL_SCALE      32'h80000000

`endif

// file: hw/sfam_i2c_slave.v
`timescale 1ns/1ns
module sfam_i2c_slave #(
  parameter [6:0] DEV_ADDR = 7'h48
) (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       sclIn,
  input  wire       sdaIn,
  output reg        sdaOe,
  output reg  [7:0] regAddr,
  output reg  [7:0] wrData,
  output reg        wrEn,
  input  wire [7:0] rdData
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACK  = 3'h2;
  localparam [2:0] ST_WR   = 3'h3;
  localparam [2:0] ST_RD   = 3'h4;
  localparam [2:0] ST_RACK = 3'h5;

  reg [1:0] sclSync;
  reg [1:0] sdaSync;
  reg       sclP;
  reg       sdaP;
  reg [2:0] state;
  reg [3:0] bitCnt;
  reg [7:0] shReg;
  reg [7:0] txByte;
  reg       readMode;
  reg       ptrLoaded;

  wire sclS    = sclSync[1];
  wire sdaS    = sdaSync[1];
  wire sclRise = sclS & ~sclP;
  wire sclFall = ~sclS & sclP;
  wire startC  = sclS & sdaP & ~sdaS;
  wire stopC   = sclS & ~sdaP & sdaS;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclSync   <= 2'h3;
      sdaSync   <= 2'h3;
      sclP      <= 1'b1;
      sdaP      <= 1'b1;
      state     <= ST_IDLE;
      bitCnt    <= 4'h0;
      shReg     <= 8'h00;
      txByte    <= 8'h00;
      readMode  <= 1'b0;
      ptrLoaded <= 1'b0;
      sdaOe     <= 1'b0;
      regAddr   <= 8'h00;
      wrData    <= 8'h00;
      wrEn      <= 1'b0;
    end else begin
      sclSync <= {sclSync[0], sclIn};
      sdaSync <= {sdaSync[0], sdaIn};
      sclP    <= sclS;
      sdaP    <= sdaS;
      wrEn    <= 1'b0;
      if (startC) begin
        state     <= ST_ADDR;
        bitCnt    <= 4'h0;
        ptrLoaded <= 1'b0;
        sdaOe     <= 1'b0;
      end else if (stopC) begin
        state <= ST_IDLE;
        sdaOe <= 1'b0;
      end else begin
        case (state)
          ST_ADDR, ST_WR: begin
            if (sclRise && bitCnt != 4'h8) begin
              shReg  <= {shReg[6:0], sdaS};
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == 4'h8) begin
              bitCnt <= 4'h0;
              if (state == ST_ADDR) begin
                if (shReg[7:1] == DEV_ADDR) begin
                  readMode <= shReg[0];
                  sdaOe    <= 1'b1;
                  state    <= ST_ACK;
                end else begin
                  state <= ST_IDLE;
                end
              end else begin
                sdaOe    <= 1'b1;
                state    <= ST_ACK;
                readMode <= 1'b0;
                if (!ptrLoaded) begin
                  regAddr   <= shReg;
                  ptrLoaded <= 1'b1;
                end else begin
                  wrData <= shReg;
                  wrEn   <= 1'b1;
                end
              end
            end
          end
          ST_ACK: begin
            if (sclFall) begin
              if (readMode) begin
                txByte <= rdData;
                sdaOe  <= ~rdData[7];
                state  <= ST_RD;
              end else begin
                sdaOe <= 1'b0;
                state <= ST_WR;
              end
            end
            // wrEn is high only in the first cycle of the ack, after the write used the old pointer
            if (wrEn) begin
              regAddr <= regAddr + 8'h01;
            end
          end
          ST_RD: begin
            if (sclFall) begin
              if (bitCnt == 4'h7) begin
                bitCnt <= 4'h0;
                sdaOe  <= 1'b0;
                state  <= ST_RACK;
              end else begin
                bitCnt <= bitCnt + 4'h1;
                txByte <= {txByte[6:0], 1'b0};
                sdaOe  <= ~txByte[6];
              end
            end
          end
          ST_RACK: begin
            if (sclRise) begin
              if (sdaS) begin
                state <= ST_IDLE;
              end else begin
                regAddr <= regAddr + 8'h01;
                state   <= ST_ACK;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // sfam_i2c_slave

// file: bench/sfam_monitor.sv
`timescale 1ns/1ns
module sfam_monitor (
  input logic        clk,
  input logic        rst_b,
  input logic [31:0] sampleLeft_q,
  input logic [31:0] sampleRight_q,
  input logic        sampleValid_q,
  input logic        silenceActive_q,
  input logic        muteAll_q,
  input logic        rampToGround_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_sil_clears: assert property (
    $fell(silenceActive_q) |-> ##[0:2] (!muteAll_q && !rampToGround_q)) else $error("response held after silence");
  a_idle_quiet: assert property (
    !silenceActive_q [*3] |-> (!muteAll_q && !rampToGround_q)) else $error("response without silence");
  a_mute_cause: assert property (
    $rose(muteAll_q) |-> silenceActive_q) else $error("mute rose without silence");
  a_ramp_cause: assert property (
    $rose(rampToGround_q) |-> silenceActive_q) else $error("ramp rose without silence");
  a_mute_first: assert property (
    !($rose(muteAll_q) && $rose(rampToGround_q))) else $error("mute and ramp rose together");
  a_resp_lags: assert property (
    $rose(silenceActive_q) |-> (!muteAll_q && !rampToGround_q)) else $error("response ahead of silence");
  a_valid_pulse: assert property (
    sampleValid_q |=> !sampleValid_q) else $error("valid longer than one cycle");
  a_right_valid: assert property (
    $changed(sampleRight_q) |-> sampleValid_q) else $error("right word changed without valid");
  a_left_first: assert property (
    sampleValid_q |-> $stable(sampleLeft_q)) else $error("left word changed with right");
endmodule // sfam_monitor

bind sfam_top sfam_monitor i_mon (
  .clk            (clk),
  .rst_b          (rst_b),
  .sampleLeft_q   (sampleLeft_q),
  .sampleRight_q  (sampleRight_q),
  .sampleValid_q  (sampleValid_q),
  .silenceActive_q(silenceActive_q),
  .muteAll_q      (muteAll_q),
  .rampToGround_q (rampToGround_q)
);

// file: bench/sfam_audio_src.sv
`timescale 1ns/1ns
module sfam_audio_src (
  output logic bitClkIn,
  output logic lrClkIn,
  output logic serDataIn
);
  logic carry;

  initial begin
    bitClkIn = 1'b0;
    lrClkIn = 1'b0;
    serDataIn = 1'b0;
    carry = 1'b0;
  end

  // ----------------------------------------
  // one bit clock, lines change while it is low
  // ----------------------------------------
  task automatic edge1(input logic lr, input logic d);
    lrClkIn <= lr;
    serDataIn <= d;
    #80 bitClkIn <= 1'b1;
    #80 bitClkIn <= 1'b0;
  endtask

  // pads carry the inverted sign so misplaced words show up
  task automatic half(input logic lr, input logic [31:0] w, input int s, input int wd, input int fmt);
    int k;
    for (int i = 0; i < s; i++) begin
      k = (fmt >= 2) ? i - (s - wd) : (fmt == 1) ? i : i - 1;
      if (fmt == 0 && i == 0) edge1(lr, carry);
      else edge1(lr, (k >= 0 && k < wd) ? w[31 - k] : ~w[31]);
    end
    carry = (wd >= s) ? w[32 - s] : ~w[31];
  endtask

  task automatic frame(input logic [31:0] l, input logic [31:0] r, input int s, input int wd, input int fmt);
    half(fmt != 0, l, s, wd, fmt);
    half(fmt == 0, r, s, wd, fmt);
  endtask

  task automatic lead(input int fmt);
    edge1(fmt == 0, ~serDataIn);
  endtask

  // i2s needs one more edge to close the last word, then one more with word select high; then the clock stops
  task automatic tail(input int fmt);
    if (fmt == 0) begin
      edge1(1'b0, carry);
      edge1(1'b1, ~carry);
    end
    serDataIn <= ~serDataIn;
  endtask
endmodule // sfam_audio_src

// file: bench/testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam int Q = 13;
  logic        clk, rst_b, sclIn, sdaDrv;
  wire         sdaIn, sdaOut, sdaOe, bitClkIn, lrClkIn, serDataIn;
  wire  [31:0] sampleLeft_q, sampleRight_q;
  wire         sampleValid_q, silenceActive_q, muteAll_q, rampToGround_q;
  int          n_fail, n_checks, f, c, w, s, wd;
  logic [31:0] seed, l, r, msk;
  logic [63:0] expQ[$];

  // open drain with pull-up
  assign sdaIn = sdaDrv & (sdaOe ? sdaOut : 1'b1);

  // short silence limit so that a silence condition fits in the run
  sfam_top #(.DEV_ADDR(7'h48), .SIL_LIMIT(22'd700)) i_dut (
    .clk(clk), .rst_b(rst_b), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .bitClkIn(bitClkIn), .lrClkIn(lrClkIn), .serDataIn(serDataIn),
    .sampleLeft_q(sampleLeft_q), .sampleRight_q(sampleRight_q), .sampleValid_q(sampleValid_q),
    .silenceActive_q(silenceActive_q), .muteAll_q(muteAll_q), .rampToGround_q(rampToGround_q));

  sfam_audio_src i_src (.bitClkIn(bitClkIn), .lrClkIn(lrClkIn), .serDataIn(serDataIn));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d failures=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ----------------------------------------
  // two-wire register access
  // ----------------------------------------
  task automatic sbit(input logic b, output logic q);
    sdaDrv <= b;
    wt(Q);
    sclIn <= 1'b1;
    wt(Q);
    q = sdaIn;
    wt(Q);
    sclIn <= 1'b0;
    wt(Q);
  endtask

  task automatic start();
    sdaDrv <= 1'b1;
    wt(Q);
    sclIn <= 1'b1;
    wt(Q);
    sdaDrv <= 1'b0;
    wt(Q);
    sclIn <= 1'b0;
    wt(Q);
  endtask

  task automatic stop();
    sdaDrv <= 1'b0;
    wt(Q);
    sclIn <= 1'b1;
    wt(Q);
    sdaDrv <= 1'b1;
    wt(Q);
  endtask

  task automatic xfer(input logic [7:0] o, output logic [7:0] i, output logic ack);
    for (int b = 7; b >= 0; b--) sbit(o[b], i[b]);
    sbit(1'b1, ack);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    logic       k;
    start();
    xfer(8'h90, x, k);
    xfer(a, x, k);
    xfer(d, x, k);
    stop();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] x;
    logic       k;
    start();
    xfer(8'h90, x, k);
    xfer(a, x, k);
    start();
    xfer(8'h91, x, k);
    xfer(8'hff, x, k);
    stop();
    chk(x, e);
  endtask

  // ----------------------------------------
  // sample watcher
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst_b === 1'b1 && sampleValid_q === 1'b1)
      chk({sampleLeft_q, sampleRight_q}, expQ.size() ? expQ.pop_front() : 64'hx);
  end

  initial begin
    #950000;
    n_fail++;
    stop_test();
  end

  initial begin
    seed = 32'hf37a9803;
    rst_b = 1'b0;
    sclIn = 1'b1;
    sdaDrv = 1'b1;
    wt(4);
    rst_b <= 1'b1;
    wt(4);
    rd(8'h02, 8'h3c);
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h68);
    wr(8'h03, 8'hff);
    wr(8'h05, 8'hff);
    wr(8'h20, 8'h5a);
    rd(8'h03, 8'h00);
    rd(8'h05, 8'h7f);
    rd(8'h20, 8'h00);
    wr(8'h02, 8'hc5);
    wr(8'h04, 8'h11);
    rd(8'h02, 8'hc5);
    wr(8'h00, 8'h01);
    rd(8'h00, 8'h00);
    rd(8'h02, 8'h3c);
    rd(8'h04, 8'h00);
    rd(8'h05, 8'h68);
    for (int i = 0; i < 8; i++) begin
      f = i / 2;
      c = i % 4;
      w = rnd() % (c + 1);
      wr(8'h02, {2'b00, w[1:0], c[1:0], f[1:0]});
      s = (c == 0) ? 16 : (c == 1) ? 24 : 32;
      wd = (w == 0) ? 16 : (w == 1) ? 24 : 32;
      msk = ~(32'hffffffff >> wd);
      i_src.lead(f);
      repeat (2) begin
        l = rnd();
        r = rnd();
        expQ.push_back({l & msk, r & msk});
        i_src.frame(l, r, s, wd, f);
      end
      i_src.tail(f);
      wt(20);
    end
    for (int m = 0; m < 4; m++) begin
      if (m == 1) wr(8'h04, 8'hff);
      wr(8'h02, {m[1:0], 6'h3d});
      i_src.lead(1);
      expQ.push_back({32'h40000000, 32'h40000000});
      i_src.frame(32'h40000000, 32'h40000000, 32, 32, 1);
      chk({silenceActive_q, muteAll_q, rampToGround_q}, 3'b000);
      for (int q = 0; q < 4; q++) begin
        expQ.push_back(64'h0);
        i_src.frame(32'h0, 32'h0, 32, 32, 1);
        if (q == 1) chk(silenceActive_q, 1'b0);
      end
      i_src.tail(1);
      wt(10);
      chk({silenceActive_q, muteAll_q, rampToGround_q}, {m != 0, m[0], m[1]});
    end
    chk(expQ.size(), 0);
    stop_test();
  end
endmodule // testbench
